// File: pmc_top.sv
// Power mode controller: mode state machine, clock and supply control, bus slave
`timescale 1ns/1ps
module pmc_top
    import pmc_pkg::*;
#(
    parameter int SETTLE_CYC = REG_SETTLE_CYC
)
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // Wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [pmc_pkg::ADR_W-1:0] WB_ADR_I,
    input wire logic [pmc_pkg::DAT_W-1:0] WB_DAT_I,
    input wire logic [pmc_pkg::SEL_W-1:0] WB_SEL_I,
    output logic [pmc_pkg::DAT_W-1:0] WB_DAT_O,
    output logic WB_ACK_O,
    // Wake sources
    input wire logic [pmc_pkg::WAKE_W-1:0] WAKE_EVT,
    input wire logic RTC_IRQ,
    input wire logic [pmc_pkg::HWAKE_W-1:0] HIB_WAKE,
    input wire logic RESET_PIN,
    // Clock, PLL and supply control
    output logic CORE_CLK_EN,
    output logic SYS_CLK_EN,
    output logic PLL_EN,
    output logic PLL_BYPASS,
    output logic REG_ON,
    output logic [pmc_pkg::VOLT_W-1:0] CORE_VOLT,
    // System gating
    output logic DMA_L1_EN,
    output logic ASYNC_BLOCK,
    output logic PIN_HIZ,
    output logic HW_RESET,
    output logic [2:0] MODE
);
    import pmc_pkg::*;

    pmc_reg_if rif();

    pmc_regs u_regs (
        .clk (CLK),
        .rst_b (RST_B),
        .rif (rif)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Wishbone slave

    logic ack_q, ack_d;
    logic cmd_q, cmd_d;
    logic [2:0] cmd_code_q, cmd_code_d;
    logic take;

    // Request taken one edge after it appears; ack drops the cycle after
    assign take = WB_CYC_I && WB_STB_I && !ack_q;

    always_comb
    begin
        ack_d = take;
        cmd_d = take && WB_WE_I && (WB_ADR_I == ADR_MODE_CMD) && WB_SEL_I[0];
        cmd_code_d = cmd_d ? WB_DAT_I[2:0] : cmd_code_q;
    end

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            ack_q <= 1'b0;
            cmd_q <= 1'b0;
            cmd_code_q <= ST_FULL_ON;
        end
        else
        begin
            ack_q <= ack_d;
            cmd_q <= cmd_d;
            cmd_code_q <= cmd_code_d;
        end
    end

    assign WB_ACK_O = ack_q;
    assign WB_DAT_O = rif.rdata;
    assign rif.we = take && WB_WE_I;
    assign rif.addr = WB_ADR_I;
    assign rif.wdata = WB_DAT_I;
    assign rif.sel = WB_SEL_I;

    ////////////////////////////////////////////////////////////////////////////
    // Mode state machine

    pmc_state_e state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic sleep_wake, hib_wake;
    logic core_d, sys_d, pllen_d, byp_d, regon_d, dma_d, blk_d, hiz_d, hwrst_d;
    logic [VOLT_W-1:0] volt_d;

    assign sleep_wake = |(WAKE_EVT & rif.wake_en);
    // Reset pin always wakes hibernate, other sources only when enabled
    assign hib_wake = |(HIB_WAKE & rif.hwake_en) || RESET_PIN;

    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        hwrst_d = 1'b0;
        unique case (state_q)
            ST_FULL_ON, ST_ACTIVE:
            begin
                if (RESET_PIN)
                begin
                    state_d = ST_FULL_ON;
                    hwrst_d = 1'b1;
                end
                else if (cmd_q)
                begin
                    // Full-on and sleep assume the PLL was re-enabled first
                    unique case (cmd_code_q)
                        ST_FULL_ON: state_d = ST_FULL_ON;
                        ST_ACTIVE: state_d = ST_ACTIVE;
                        ST_SLEEP: state_d = ST_SLEEP;
                        ST_DEEP: state_d = ST_DEEP;
                        ST_HIBERNATE: state_d = ST_HIBERNATE;
                        default: state_d = state_q;
                    endcase
                end
            end
            ST_SLEEP:
            begin
                if (RESET_PIN)
                begin
                    state_d = ST_FULL_ON;
                    hwrst_d = 1'b1;
                end
                else if (sleep_wake)
                    state_d = rif.bypass ? ST_ACTIVE : ST_FULL_ON;
            end
            ST_DEEP:
            begin
                if (RESET_PIN)
                begin
                    state_d = ST_FULL_ON;
                    hwrst_d = 1'b1;
                end
                else if (RTC_IRQ)
                    state_d = ST_ACTIVE;
            end
            ST_HIBERNATE:
            begin
                if (hib_wake)
                begin
                    state_d = ST_WAKE_RST;
                    cnt_d = '0;
                end
            end
            ST_WAKE_RST:
            begin
                // Regulator ramps before the reset sequence starts
                if (cnt_q == CNT_W'(SETTLE_CYC - 1))
                begin
                    state_d = ST_FULL_ON;
                    hwrst_d = 1'b1;
                end
                else
                    cnt_d = cnt_q + 1'b1;
            end
            default: state_d = ST_FULL_ON;
        endcase
    end

    // Outputs decoded from the next state so they register in step with it
    always_comb
    begin
        core_d = 1'b0;
        sys_d = 1'b0;
        pllen_d = 1'b0;
        byp_d = 1'b0;
        regon_d = 1'b1;
        dma_d = 1'b0;
        blk_d = 1'b0;
        hiz_d = 1'b0;
        volt_d = rif.volt;
        unique case (state_d)
            ST_FULL_ON:
            begin
                core_d = 1'b1;
                sys_d = 1'b1;
                pllen_d = 1'b1;
                dma_d = 1'b1;
            end
            ST_ACTIVE:
            begin
                core_d = 1'b1;
                sys_d = 1'b1;
                byp_d = 1'b1;
                pllen_d = !rif.pll_off;
                dma_d = 1'b1;
            end
            ST_SLEEP:
            begin
                sys_d = 1'b1;
                pllen_d = 1'b1;
                dma_d = 1'b0;
            end
            ST_DEEP:
                blk_d = 1'b1;
            ST_HIBERNATE:
            begin
                blk_d = 1'b1;
                regon_d = 1'b0;
                volt_d = VOLT_ZERO;
                hiz_d = 1'b1;
            end
            ST_WAKE_RST:
                blk_d = 1'b1;
            default: ;
        endcase
    end

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            state_q <= ST_FULL_ON;
            cnt_q <= '0;
            CORE_CLK_EN <= 1'b1;
            SYS_CLK_EN <= 1'b1;
            PLL_EN <= 1'b1;
            PLL_BYPASS <= 1'b0;
            REG_ON <= 1'b1;
            CORE_VOLT <= VOLT_RST;
            DMA_L1_EN <= 1'b1;
            ASYNC_BLOCK <= 1'b0;
            PIN_HIZ <= 1'b0;
            HW_RESET <= 1'b0;
            MODE <= ST_FULL_ON;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            CORE_CLK_EN <= core_d;
            SYS_CLK_EN <= sys_d;
            PLL_EN <= pllen_d;
            PLL_BYPASS <= byp_d;
            REG_ON <= regon_d;
            CORE_VOLT <= volt_d;
            DMA_L1_EN <= dma_d;
            ASYNC_BLOCK <= blk_d;
            PIN_HIZ <= hiz_d;
            HW_RESET <= hwrst_d;
            MODE <= state_d;
        end
    end

    // Entering hibernate drops the volatile registers
    assign rif.lose = (state_q == ST_HIBERNATE);

    always_comb
    begin
        rif.status = '0;
        rif.status[STAT_STATE_LSB +: 3] = state_q;
        rif.status[STAT_PLL_EN_BIT] = PLL_EN;
        rif.status[STAT_REG_ON_BIT] = REG_ON;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_B);

    full_on_pll_a: assert property (
        state_q == ST_FULL_ON |-> PLL_EN && !PLL_BYPASS && CORE_CLK_EN && SYS_CLK_EN)
        else $error("full-on with wrong PLL or clocks");

    active_bypass_a: assert property (
        state_q == ST_ACTIVE |-> PLL_BYPASS && CORE_CLK_EN && SYS_CLK_EN && DMA_L1_EN)
        else $error("active mode not bypassed");

    pll_shutdown_a: assert property (
        state_q == ST_ACTIVE |-> PLL_EN == !$past(rif.pll_off))
        else $error("PLL shutdown bit not honoured");

    sleep_clocks_a: assert property (
        state_q == ST_SLEEP |-> !CORE_CLK_EN && SYS_CLK_EN && PLL_EN && !DMA_L1_EN)
        else $error("sleep clock gating wrong");

    sleep_wake_a: assert property (
        state_q == ST_SLEEP && sleep_wake && !RESET_PIN
        |=> state_q == ($past(rif.bypass) ? ST_ACTIVE : ST_FULL_ON))
        else $error("sleep wake went to wrong mode");

    deep_exit_a: assert property (
        state_q == ST_DEEP && !RESET_PIN && RTC_IRQ |=> state_q == ST_ACTIVE)
        else $error("RTC did not wake deep sleep to active");

    deep_reset_a: assert property (
        state_q == ST_DEEP && RESET_PIN |=> state_q == ST_FULL_ON && HW_RESET)
        else $error("reset did not take deep sleep to full-on");

    hib_power_a: assert property (
        state_q == ST_HIBERNATE
        |-> !REG_ON && CORE_VOLT == VOLT_ZERO && PIN_HIZ && !CORE_CLK_EN && !SYS_CLK_EN)
        else $error("hibernate left power or pins on");

    hib_wake_a: assert property (
        state_q == ST_HIBERNATE && RESET_PIN |=> state_q == ST_WAKE_RST && REG_ON && !HW_RESET)
        else $error("hibernate wake did not start regulator");

endmodule

// File: pmc_pkg.sv
// Constants, register map and state codes for the power mode controller
package pmc_pkg;

    // Wishbone geometry
    localparam int ADR_W = 8;
    localparam int DAT_W = 32;
    localparam int SEL_W = 4;

    // Register byte addresses
    localparam logic [7:0] ADR_PLL_CTRL = 8'h00;
    localparam logic [7:0] ADR_WAKE_EN = 8'h04;
    localparam logic [7:0] ADR_REG_CTRL = 8'h08;
    localparam logic [7:0] ADR_MODE_CMD = 8'h0C;
    localparam logic [7:0] ADR_STATUS = 8'h10;

    // PLL control fields
    localparam int PLL_BYPASS_BIT = 0;
    localparam int PLL_OFF_BIT = 1;
    localparam int PLL_CTRL_W = 2;
    localparam logic [1:0] PLL_CTRL_RST = 2'h0;

    // Sleep wakeup enables
    localparam int WAKE_W = 8;
    localparam logic [7:0] WAKE_EN_RST = 8'h00;

    // Regulator control: voltage code in low byte, hibernate wake enables above
    localparam int VOLT_W = 8;
    localparam int VOLT_LSB = 0;
    localparam int HWAKE_W = 7;
    localparam int HWAKE_LSB = 8;
    localparam int VOLT_STEP_MV = 50;
    localparam logic [7:0] VOLT_RST = 8'h14;
    localparam logic [6:0] HWAKE_RST = 7'h7F;
    localparam logic [7:0] VOLT_ZERO = 8'h00;

    // Hibernate wake source positions
    localparam int HW_CAN = 0;
    localparam int HW_MEDIA = 1;
    localparam int HW_KEYPAD = 2;
    localparam int HW_COUNTER = 3;
    localparam int HW_USB = 4;
    localparam int HW_GPIO = 5;
    localparam int HW_RTC = 6;

    // Status fields
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_PLL_EN_BIT = 4;
    localparam int STAT_REG_ON_BIT = 5;

    // Regulator settle time before the reset sequence starts
    localparam int CLK_PERIOD_NS = 40;
    localparam int REG_SETTLE_NS = 10000;
    localparam int REG_SETTLE_CYC = (REG_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 16;

    typedef enum logic [2:0] {
        ST_FULL_ON = 3'h0,
        ST_ACTIVE = 3'h1,
        ST_SLEEP = 3'h2,
        ST_DEEP = 3'h3,
        ST_HIBERNATE = 3'h4,
        ST_WAKE_RST = 3'h5
    } pmc_state_e;

endpackage

// File: pmc_reg_if.sv
// Interface between the controller core and its register store
`timescale 1ns/1ps
interface pmc_reg_if;
    import pmc_pkg::*;

    logic we;
    logic [ADR_W-1:0] addr;
    logic [DAT_W-1:0] wdata;
    logic [SEL_W-1:0] sel;
    logic lose;
    logic [DAT_W-1:0] status;
    logic [DAT_W-1:0] rdata;
    logic bypass;
    logic pll_off;
    logic [WAKE_W-1:0] wake_en;
    logic [VOLT_W-1:0] volt;
    logic [HWAKE_W-1:0] hwake_en;

    modport core (output we, addr, wdata, sel, lose, status,
                  input rdata, bypass, pll_off, wake_en, volt, hwake_en);
    modport store (input we, addr, wdata, sel, lose, status,
                   output rdata, bypass, pll_off, wake_en, volt, hwake_en);
endinterface

// File: pmc_regs.sv
// Software register store with registered read data
`timescale 1ns/1ps
module pmc_regs
    import pmc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Core side
    pmc_reg_if.store rif
);

    logic [PLL_CTRL_W-1:0] pll_q, pll_d;
    logic [WAKE_W-1:0] wake_q, wake_d;
    logic [VOLT_W-1:0] volt_q, volt_d;
    logic [HWAKE_W-1:0] hwake_q, hwake_d;
    logic [DAT_W-1:0] rdata_q, rdata_d;
    logic [DAT_W-1:0] merged;

    function automatic logic [DAT_W-1:0] lane_merge(input logic [DAT_W-1:0] old_v,
                                                    input logic [DAT_W-1:0] new_v,
                                                    input logic [SEL_W-1:0] sel);
        logic [DAT_W-1:0] res;
        res = old_v;
        for (int i = 0; i < SEL_W; i++)
        begin
            if (sel[i])
                res[i*8 +: 8] = new_v[i*8 +: 8];
        end
        return res;
    endfunction

    always_comb
    begin
        pll_d = pll_q;
        wake_d = wake_q;
        volt_d = volt_q;
        hwake_d = hwake_q;
        rdata_d = '0;
        merged = '0;
        unique case (rif.addr)
            ADR_PLL_CTRL: rdata_d[PLL_CTRL_W-1:0] = pll_q;
            ADR_WAKE_EN: rdata_d[WAKE_W-1:0] = wake_q;
            ADR_REG_CTRL:
            begin
                rdata_d[VOLT_LSB +: VOLT_W] = volt_q;
                rdata_d[HWAKE_LSB +: HWAKE_W] = hwake_q;
            end
            ADR_STATUS: rdata_d = rif.status;
            default: rdata_d = '0;
        endcase
        if (rif.we)
        begin
            unique case (rif.addr)
                ADR_PLL_CTRL:
                begin
                    merged = lane_merge({{(DAT_W-PLL_CTRL_W){1'b0}}, pll_q}, rif.wdata, rif.sel);
                    pll_d = merged[PLL_CTRL_W-1:0];
                end
                ADR_WAKE_EN:
                begin
                    merged = lane_merge({{(DAT_W-WAKE_W){1'b0}}, wake_q}, rif.wdata, rif.sel);
                    wake_d = merged[WAKE_W-1:0];
                end
                ADR_REG_CTRL:
                begin
                    merged = lane_merge({{(DAT_W-HWAKE_LSB-HWAKE_W){1'b0}}, hwake_q, volt_q},
                                        rif.wdata, rif.sel);
                    volt_d = merged[VOLT_LSB +: VOLT_W];
                    hwake_d = merged[HWAKE_LSB +: HWAKE_W];
                end
                default: ;
            endcase
        end
        // Core power loss wipes all but regulator control
        if (rif.lose)
        begin
            pll_d = PLL_CTRL_RST;
            wake_d = WAKE_EN_RST;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pll_q <= PLL_CTRL_RST;
            wake_q <= WAKE_EN_RST;
            volt_q <= VOLT_RST;
            hwake_q <= HWAKE_RST;
            rdata_q <= '0;
        end
        else
        begin
            pll_q <= pll_d;
            wake_q <= wake_d;
            volt_q <= volt_d;
            hwake_q <= hwake_d;
            rdata_q <= rdata_d;
        end
    end

    assign rif.rdata = rdata_q;
    assign rif.bypass = pll_q[PLL_BYPASS_BIT];
    assign rif.pll_off = pll_q[PLL_OFF_BIT];
    assign rif.wake_en = wake_q;
    assign rif.volt = volt_q;
    assign rif.hwake_en = hwake_q;

endmodule

// File: pmc_wake_model.sv
// Model of the external wake sources: sleep events, RTC, hibernate sources, reset pin
`timescale 1ns/1ps
module pmc_wake_model
    import pmc_pkg::*;
(
    // Clock
    input wire logic clk,
    // Wake requests, all active high levels
    output logic [pmc_pkg::WAKE_W-1:0] wake_evt,
    output logic rtc_irq,
    output logic [pmc_pkg::HWAKE_W-1:0] hib_wake,
    output logic reset_pin
);
    initial
    begin
        wake_evt = '0;
        rtc_irq = 1'b0;
        hib_wake = '0;
        reset_pin = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Kind 0 sleep event, 1 RTC, 2 hibernate source, 3 reset pin; held for hold cycles
    // Released sources drop to idle low, the level a real source rests at
    task automatic fire(input int kind, input logic [7:0] bits, input int hold);
        @(posedge clk);
        case (kind)
            0: wake_evt <= bits;
            1: rtc_irq <= 1'b1;
            2: hib_wake <= bits[6:0];
            default: reset_pin <= 1'b1;
        endcase
        repeat (hold) @(posedge clk);
        wake_evt <= '0;
        rtc_irq <= 1'b0;
        hib_wake <= '0;
        reset_pin <= 1'b0;
    endtask
endmodule

// File: power_mode_controller_tb_top.sv
// Self-checking bench for the power mode controller
`timescale 1ns/1ps
module power_mode_controller_tb_top;
    import pmc_pkg::*;
    localparam int SETTLE = 4;
    // Packed outputs: core, sys, pll, bypass, reg, dma, async, hiz, mode
    localparam logic [10:0] V_FULL = 11'h760;
    localparam logic [10:0] V_ACT = 11'h7E1;
    localparam logic [10:0] V_SLEEP = 11'h342;
    localparam logic [10:0] V_DEEP = 11'h053;
    localparam logic [10:0] V_HIB = 11'h00C;
    localparam logic [10:0] M_ALL = 11'h7FF;
    localparam logic [10:0] M_SLEEP = 11'h76F;
    localparam logic [10:0] M_DEEP = 11'h757;
    localparam logic [10:0] M_HIB = 11'h74F;
    logic CLK, RST_B, WB_CYC_I, WB_STB_I, WB_WE_I;
    logic [ADR_W-1:0] WB_ADR_I;
    logic [DAT_W-1:0] WB_DAT_I;
    logic [SEL_W-1:0] WB_SEL_I;
    logic [DAT_W-1:0] WB_DAT_O;
    logic WB_ACK_O, CORE_CLK_EN, SYS_CLK_EN, PLL_EN, PLL_BYPASS, REG_ON;
    logic DMA_L1_EN, ASYNC_BLOCK, PIN_HIZ, HW_RESET;
    logic [VOLT_W-1:0] CORE_VOLT;
    logic [2:0] MODE;
    logic [WAKE_W-1:0] wake_evt;
    logic [HWAKE_W-1:0] hib_wake;
    logic rtc_irq, reset_pin;
    logic [10:0] outs;
    int n_mismatch = 0;
    int check_count = 0;
    logic [31:0] saved;
    assign outs = {CORE_CLK_EN, SYS_CLK_EN, PLL_EN, PLL_BYPASS, REG_ON, DMA_L1_EN,
                   ASYNC_BLOCK, PIN_HIZ, MODE};

    pmc_top #(.SETTLE_CYC(SETTLE)) dut (.CLK(CLK), .RST_B(RST_B), .WB_CYC_I(WB_CYC_I),
        .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I),
        .WB_SEL_I(WB_SEL_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .WAKE_EVT(wake_evt),
        .RTC_IRQ(rtc_irq), .HIB_WAKE(hib_wake), .RESET_PIN(reset_pin),
        .CORE_CLK_EN(CORE_CLK_EN), .SYS_CLK_EN(SYS_CLK_EN), .PLL_EN(PLL_EN),
        .PLL_BYPASS(PLL_BYPASS), .REG_ON(REG_ON), .CORE_VOLT(CORE_VOLT),
        .DMA_L1_EN(DMA_L1_EN), .ASYNC_BLOCK(ASYNC_BLOCK), .PIN_HIZ(PIN_HIZ),
        .HW_RESET(HW_RESET), .MODE(MODE));
    pmc_wake_model src (.clk(CLK), .wake_evt(wake_evt), .rtc_irq(rtc_irq),
        .hib_wake(hib_wake), .reset_pin(reset_pin));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Classic single cycle; holds everything until ack is sampled high
    // No cycle limit here: a slave that never answers is left to the watchdog
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                      output logic [31:0] rd);
        @(posedge CLK);
        WB_CYC_I <= 1'b1;
        WB_STB_I <= 1'b1;
        WB_WE_I <= we;
        WB_ADR_I <= adr;
        WB_DAT_I <= dat;
        WB_SEL_I <= 4'hF;
        do
        begin
            @(posedge CLK);
        end
        while (WB_ACK_O !== 1'b1);
        rd = WB_DAT_O;
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] d;
        wb(1'b1, adr, dat, d);
    endtask
    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] d;
        wb(1'b0, adr, 32'h0, d);
        check(d, exp);
    endtask
    // Mode outputs move one edge after the command is taken
    task automatic go(input logic [2:0] code);
        wr(ADR_MODE_CMD, {29'h0, code});
        @(posedge CLK);
        #1;
    endtask
    task automatic st(input logic [10:0] v, input logic [10:0] m);
        check({21'h0, outs & m}, {21'h0, v & m});
    endtask
    task automatic wait_full;
        int n;
        n = 0;
        while (MODE !== 3'h0 && n < 20)
        begin
            @(posedge CLK);
            #1;
            n++;
        end
        check(n, SETTLE);
        check(HW_RESET, 1'b1);
        @(posedge CLK);
        #1;
        check(HW_RESET, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        CLK = 1'b0;
        forever #20 CLK = ~CLK;
    end
    // Tests take well under 2000 cycles
    initial
    begin
        #(40 * 5000);
        n_mismatch++;
        finish_test();
    end

    initial
    begin
        RST_B <= 1'b0;
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
        WB_WE_I <= 1'b0;
        WB_ADR_I <= 8'h00;
        WB_DAT_I <= 32'h0;
        WB_SEL_I <= 4'h0;
        repeat (3) @(posedge CLK);
        RST_B <= 1'b1;
        #1;
        st(V_FULL, M_ALL);
        check(CORE_VOLT, VOLT_RST);
        rd_chk(ADR_PLL_CTRL, 32'h0);
        rd_chk(ADR_WAKE_EN, 32'h0);
        rd_chk(ADR_REG_CTRL, 32'h7F14);
        rd_chk(ADR_STATUS, 32'h30);
        wr(8'h14, 32'hFFFFFFFF);
        rd_chk(8'h14, 32'h0);
        $display("test reset done");

        wr(ADR_PLL_CTRL, 32'h1);
        go(3'h1);
        st(V_ACT, M_ALL);
        wr(ADR_PLL_CTRL, 32'h3);
        repeat (2) @(posedge CLK);
        #1;
        check(PLL_EN, 1'b0);
        rd_chk(ADR_STATUS, 32'h21);
        wr(ADR_PLL_CTRL, 32'h1);
        repeat (2) @(posedge CLK);
        #1;
        check(PLL_EN, 1'b1);
        $display("test active done");

        wr(ADR_WAKE_EN, 32'h04);
        for (int b = 1; b >= 0; b--)
        begin
            wr(ADR_PLL_CTRL, b);
            go(3'h2);
            st(V_SLEEP, M_SLEEP);
            src.fire(0, 8'hFB, 3);
            #1;
            st(V_SLEEP, M_SLEEP);
            src.fire(0, 8'h04, 1);
            #1;
            st((b == 1) ? V_ACT : V_FULL, M_ALL);
        end
        $display("test sleep done");

        go(3'h3);
        st(V_DEEP, M_DEEP);
        go(3'h0);
        src.fire(0, 8'h04, 1);
        #1;
        st(V_DEEP, M_DEEP);
        src.fire(1, 8'h00, 1);
        #1;
        st(V_ACT, M_ALL);
        go(3'h3);
        src.fire(3, 8'h00, 1);
        #1;
        st(V_FULL, M_ALL);
        check(HW_RESET, 1'b1);
        // Reset pin in sleep also restarts into full-on
        go(3'h2);
        st(V_SLEEP, M_SLEEP);
        src.fire(3, 8'h00, 1);
        #1;
        st(V_FULL, M_ALL);
        check(HW_RESET, 1'b1);
        $display("test deep sleep done");

        wr(ADR_REG_CTRL, 32'h7F1E);
        repeat (2) @(posedge CLK);
        #1;
        check(CORE_VOLT, 8'h1E);
        // Software keeps the wake enables outside the core before power goes
        wb(1'b0, ADR_WAKE_EN, 32'h0, saved);
        check(saved, 32'h04);
        // Every hibernate wake source in turn, each a full wake
        for (int i = 0; i < 7; i++)
        begin
            go(3'h4);
            st(V_HIB, M_HIB);
            check(CORE_VOLT, VOLT_ZERO);
            src.fire(2, 8'h01 << i, 1);
            #1;
            check({REG_ON, MODE}, 4'hD);
            wait_full();
        end
        st(V_FULL, M_ALL);
        check(CORE_VOLT, 8'h1E);
        rd_chk(ADR_WAKE_EN, 32'h0);
        wr(ADR_WAKE_EN, saved);
        rd_chk(ADR_WAKE_EN, 32'h04);
        rd_chk(ADR_REG_CTRL, 32'h7F1E);
        wr(ADR_REG_CTRL, 32'h7E1E);
        go(3'h4);
        src.fire(2, 8'h01, 3);
        #1;
        check(MODE, 3'h4);
        src.fire(3, 8'h00, 1);
        #1;
        check({REG_ON, MODE}, 4'hD);
        wait_full();
        $display("test hibernate done");
        finish_test();
    end
endmodule
